/* verilog/dsc_pkg.sv */
// Constants, register map and carrier types of the decimal string codec.
// Assumes a single core clock and an APB master with 8-bit byte addresses.
package dsc_pkg;

  localparam int NDIG   = 31;
  localparam int NSLOT  = 32;
  localparam int NBYTES = 16;
  localparam int NWORDS = 4;

  // Register byte addresses; the three buffers take four words each.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_SD0  = 8'h08;
  localparam logic [7:0] A_SD1  = 8'h0C;
  localparam logic [7:0] A_DD0  = 8'h10;
  localparam logic [7:0] A_DD1  = 8'h14;
  localparam logic [7:0] A_SIGN = 8'h18;
  localparam logic [7:0] A_SBUF = 8'h20;
  localparam logic [7:0] A_DBUF = 8'h30;
  localparam logic [7:0] A_DIG  = 8'h40;

  localparam int C_UNPACK = 0;
  localparam int C_PACK   = 1;
  localparam int S_BUSY   = 0;
  localparam int S_OVF    = 1;
  localparam int S_NEG    = 2;
  localparam int S_BAD    = 3;
  localparam int S_DONE   = 4;

  localparam int TYPE_HI = 14;
  localparam int TYPE_LO = 12;
  localparam int LEN_HI  = 4;
  localparam int LEN_LO  = 0;

  localparam logic [2:0] T_SZONED = 3'h0;
  localparam logic [2:0] T_UZONED = 3'h1;
  localparam logic [2:0] T_TOVER  = 3'h2;
  localparam logic [2:0] T_LOVER  = 3'h3;
  localparam logic [2:0] T_TSEP   = 3'h4;
  localparam logic [2:0] T_LSEP   = 3'h5;
  localparam logic [2:0] T_SPACK  = 3'h6;
  localparam logic [2:0] T_UPACK  = 3'h7;

  localparam logic [3:0] SG_POS  = 4'hC;
  localparam logic [3:0] SG_NEG  = 4'hD;
  localparam logic [3:0] SG_APOS = 4'hA;
  localparam logic [3:0] SG_EPOS = 4'hE;
  localparam logic [3:0] SG_UNS  = 4'hF;
  localparam logic [3:0] SG_ANEG = 4'hB;
  localparam logic [3:0] NIB_0   = 4'h0;
  localparam logic [3:0] NIB_9   = 4'h9;

  typedef struct packed {
    logic [2:0]  typ;
    logic [4:0]  len;
    logic [15:0] addr;
  } desc_t;

  typedef logic [NSLOT-1:0][3:0]  digits_t;
  typedef logic [NBYTES-1:0][7:0] bytes_t;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_WORK = 3'b010,
    PH_DONE = 3'b100
  } phase_t;

  typedef struct packed {
    phase_t      phase;
    logic        pack;
    logic [15:0] sw0;
    logic [15:0] sw1;
    logic [15:0] dw0;
    logic [15:0] dw1;
    bytes_t      sbuf;
    bytes_t      dbuf;
    digits_t     dig;
    logic        neg;
    logic        ovf;
    logic        bad;
    logic        done;
    logic [31:0] rdata;
  } state_t;

  localparam state_t ST_RST = '{phase: PH_IDLE, default: '0};

  function automatic desc_t desc_of(input logic [15:0] w0, input logic [15:0] w1);
    desc_of.typ  = w0[TYPE_HI:TYPE_LO];
    desc_of.len  = w0[LEN_HI:LEN_LO];
    desc_of.addr = w1;
  endfunction

  function automatic logic is_packed(input logic [2:0] t);
    is_packed = (t == T_SPACK) || (t == T_UPACK);
  endfunction

  // Bytes taken by a packed string: half the length, rounded down, plus one.
  function automatic logic [4:0] nbytes_of(input logic [4:0] len);
    nbytes_of = {1'b0, len[4:1]} + 5'h01;
  endfunction

endpackage

/* verilog/dsc_unpack.sv */
// Packed string bytes to digit nibbles and sign.
// Assumes bytes[0] is the lowest addressed byte of the string.
`timescale 1ns/1ns
`default_nettype none
module dsc_unpack (
  input  wire dsc_pkg::bytes_t  src,    // String bytes.
  input  wire dsc_pkg::desc_t   desc,   // Source descriptor.
  output dsc_pkg::digits_t      dig,    // Digits, index 0 least significant.
  output logic                  neg     // Source value is negative.
);
  logic [4:0] nb;
  logic [3:0] sgn;

  assign nb  = dsc_pkg::nbytes_of(desc.len);
  assign sgn = src[4'(nb - 5'h01)][3:0];

  genvar d;
  generate
    for (d = 0; d < dsc_pkg::NDIG; d = d + 1) begin : g_dig
      logic [3:0] bi;
      assign bi = 4'(nb - 5'h01 - 5'((d + 1) / 2));
      if (d % 2 == 1) begin : g_odd
        assign dig[d] = (5'(d) < desc.len) ? src[bi][3:0] : dsc_pkg::NIB_0;
      end else begin : g_even
        assign dig[d] = (5'(d) < desc.len) ? src[bi][7:4] : dsc_pkg::NIB_0;
      end
    end
  endgenerate
  assign dig[dsc_pkg::NSLOT-1] = dsc_pkg::NIB_0;

  // Zero of either sign reads as positive zero.
  assign neg = (desc.typ == dsc_pkg::T_SPACK) && (dig != '0) &&
               ((sgn == dsc_pkg::SG_NEG) || (sgn == dsc_pkg::SG_ANEG));
endmodule
`default_nettype wire

/* verilog/dsc_pack.sv */
// Digit nibbles and sign to packed string bytes, with overflow.
// Assumes dst[0] is the lowest addressed byte of the destination.
`timescale 1ns/1ns
`default_nettype none
module dsc_pack (
  input  wire dsc_pkg::digits_t dig,    // Result digits.
  input  wire logic             negIn,  // Result sign.
  input  wire dsc_pkg::desc_t   desc,   // Destination descriptor.
  output dsc_pkg::bytes_t       dst,    // Destination bytes.
  output logic                  ovf,    // Decimal overflow.
  output logic                  negOut  // Result sign, cleared for a zero result.
);
  dsc_pkg::digits_t kept;
  logic [4:0]       nb;
  logic [3:0]       sgn;

  always_comb begin
    int k;
    k = 0;
    ovf = 1'b0;
    kept = '0;
    for (int i = 0; i < dsc_pkg::NDIG; i++) begin
      if (5'(i) < desc.len) begin
        kept[i] = dig[i];
      end else if (dig[i] != dsc_pkg::NIB_0) begin
        ovf = 1'b1;
      end
    end
    // A zero result is positive, but overflow keeps a negative sign.
    negOut = negIn && (dig != '0);
    nb = dsc_pkg::nbytes_of(desc.len);
    if (desc.typ == dsc_pkg::T_UPACK) begin
      sgn = dsc_pkg::SG_UNS;
    end else begin
      sgn = negOut ? dsc_pkg::SG_NEG : dsc_pkg::SG_POS;
    end
    for (int b = 0; b < dsc_pkg::NBYTES; b++) begin
      dst[b] = '0;
      if (5'(b) < nb) begin
        k = 32'(nb) - 1 - b;
        dst[b][7:4] = kept[5'(2 * k)];
        dst[b][3:0] = (k == 0) ? sgn : kept[5'(2 * k - 1)];
      end
    end
  end
endmodule
`default_nettype wire

/* verilog/dsc_codec.sv */
// Decimal string codec: APB register file, operation sequencer, status.
// Assumes an APB master on core_clk; the execution unit reads the status pins.
`timescale 1ns/1ns
`default_nettype none

module dsc_codec (
  input  wire  logic        core_clk,    // Core clock, 10 MHz.
  input  wire  logic        nrst,        // Synchronous reset, active low.
  input  wire  logic        psel,        // APB select.
  input  wire  logic        penable,     // APB enable.
  input  wire  logic        pwrite,      // APB write.
  input  wire  logic [7:0]  paddr,       // APB byte address.
  input  wire  logic [31:0] pwdata,      // APB write data.
  output logic       [31:0] prdata,      // APB read data.
  output logic              pready,      // APB ready.
  output logic              pslverr,     // APB error on unmapped address.
  output logic              doneStrobe,  // Operation complete, one cycle.
  output logic              decOverflow, // Decimal overflow of last operation.
  output logic              resultNeg,   // Sign of last result, 1 negative.
  output logic              badType      // Reserved type code was given.
);

  // ****************************************************************
  // State and datapath
  // ****************************************************************
  dsc_pkg::state_t  st_reg;
  dsc_pkg::state_t  st_next;
  dsc_pkg::desc_t   sd;
  dsc_pkg::desc_t   dd;
  dsc_pkg::digits_t unDig;
  dsc_pkg::bytes_t  pkBytes;
  logic             unNeg;
  logic             pkOvf;
  logic             pkNeg;
  logic             acc;
  logic             startOk;

  assign sd = dsc_pkg::desc_of(st_reg.sw0, st_reg.sw1);
  assign dd = dsc_pkg::desc_of(st_reg.dw0, st_reg.dw1);

  // Source nibbles are taken as they stand; no digit or sign checking.
  dsc_unpack u_unpack (
    .src  (st_reg.sbuf),
    .desc (sd),
    .dig  (unDig),
    .neg  (unNeg)
  );

  dsc_pack u_pack (
    .dig    (st_reg.dig),
    .negIn  (st_reg.neg),
    .desc   (dd),
    .dst    (pkBytes),
    .ovf    (pkOvf),
    .negOut (pkNeg)
  );

  // ****************************************************************
  // Address decoding
  // ****************************************************************
  function automatic logic mapped(input logic [7:0] a);
    logic [3:0] grp;
    grp = a[7:4];
    mapped = (a[7:2] <= dsc_pkg::A_SIGN[7:2]) ||
             (grp == dsc_pkg::A_SBUF[7:4]) ||
             (grp == dsc_pkg::A_DBUF[7:4]) ||
             (grp == dsc_pkg::A_DIG[7:4]);
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [1:0] w;
    w = a[3:2];
    rd_word = '0;
    if (a[7:4] == dsc_pkg::A_SBUF[7:4]) begin
      rd_word = st_reg.sbuf[4 * w +: 4];
    end else if (a[7:4] == dsc_pkg::A_DBUF[7:4]) begin
      rd_word = st_reg.dbuf[4 * w +: 4];
    end else if (a[7:4] == dsc_pkg::A_DIG[7:4]) begin
      rd_word = st_reg.dig[8 * w +: 8];
    end else begin
      case (a[7:2])
        dsc_pkg::A_STAT[7:2]: begin
          rd_word[dsc_pkg::S_BUSY] = (st_reg.phase != dsc_pkg::PH_IDLE);
          rd_word[dsc_pkg::S_OVF]  = st_reg.ovf;
          rd_word[dsc_pkg::S_NEG]  = st_reg.neg;
          rd_word[dsc_pkg::S_BAD]  = st_reg.bad;
          rd_word[dsc_pkg::S_DONE] = st_reg.done;
        end
        dsc_pkg::A_SD0[7:2]:  rd_word[15:0] = st_reg.sw0;
        dsc_pkg::A_SD1[7:2]:  rd_word[15:0] = st_reg.sw1;
        dsc_pkg::A_DD0[7:2]:  rd_word[15:0] = st_reg.dw0;
        dsc_pkg::A_DD1[7:2]:  rd_word[15:0] = st_reg.dw1;
        dsc_pkg::A_SIGN[7:2]: rd_word[0] = st_reg.neg;
        default:              rd_word = '0;
      endcase
    end
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  assign acc = psel && penable;
  // Starts are honoured only while idle, so a running operation never sees
  // its inputs change underneath it.
  assign startOk = acc && pwrite && (paddr[7:2] == dsc_pkg::A_CTRL[7:2]) &&
                   (st_reg.phase == dsc_pkg::PH_IDLE) &&
                   (pwdata[dsc_pkg::C_UNPACK] || pwdata[dsc_pkg::C_PACK]);

  always_comb begin
    st_next = st_reg;
    if (psel && !penable && !pwrite) begin
      st_next.rdata = rd_word(paddr);
    end
    if (acc && pwrite && (st_reg.phase == dsc_pkg::PH_IDLE)) begin
      if (paddr[7:4] == dsc_pkg::A_SBUF[7:4]) begin
        st_next.sbuf[4 * paddr[3:2] +: 4] = pwdata;
      end else if (paddr[7:4] == dsc_pkg::A_DIG[7:4]) begin
        st_next.dig[8 * paddr[3:2] +: 8] = pwdata;
      end else begin
        case (paddr[7:2])
          dsc_pkg::A_SD0[7:2]:  st_next.sw0 = pwdata[15:0];
          dsc_pkg::A_SD1[7:2]:  st_next.sw1 = pwdata[15:0];
          dsc_pkg::A_DD0[7:2]:  st_next.dw0 = pwdata[15:0];
          dsc_pkg::A_DD1[7:2]:  st_next.dw1 = pwdata[15:0];
          dsc_pkg::A_SIGN[7:2]: st_next.neg = pwdata[0];
          default:              st_next.neg = st_reg.neg;
        endcase
      end
    end
    case (st_reg.phase)
      dsc_pkg::PH_IDLE: begin
        if (startOk) begin
          st_next.phase = dsc_pkg::PH_WORK;
          st_next.pack  = pwdata[dsc_pkg::C_PACK];
          st_next.done  = 1'b0;
        end
      end
      dsc_pkg::PH_WORK: begin
        st_next.phase = dsc_pkg::PH_DONE;
        st_next.ovf   = 1'b0;
        if (st_reg.pack) begin
          st_next.bad = !dsc_pkg::is_packed(dd.typ);
          if (dsc_pkg::is_packed(dd.typ)) begin
            st_next.dbuf = pkBytes;
            st_next.ovf  = pkOvf;
            st_next.neg  = pkNeg;
          end
        end else begin
          st_next.bad = !dsc_pkg::is_packed(sd.typ);
          if (dsc_pkg::is_packed(sd.typ)) begin
            st_next.dig = unDig;
            st_next.neg = unNeg;
          end
        end
      end
      dsc_pkg::PH_DONE: begin
        st_next.phase = dsc_pkg::PH_IDLE;
        st_next.done  = 1'b1;
      end
      default: begin
        st_next.phase = dsc_pkg::PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_reg <= dsc_pkg::ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata      = st_reg.rdata;
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !mapped(paddr);
  assign doneStrobe  = (st_reg.phase == dsc_pkg::PH_DONE);
  assign decOverflow = st_reg.ovf;
  assign resultNeg   = st_reg.neg;
  assign badType     = st_reg.bad;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [4:0] dnb;
  logic [4:0] snb;
  logic [7:0] dLast;
  logic [3:0] srcSign;
  logic       pkDone;

  assign dnb     = dsc_pkg::nbytes_of(dd.len);
  assign snb     = dsc_pkg::nbytes_of(sd.len);
  assign dLast   = st_reg.dbuf[4'(dnb - 5'h01)];
  assign srcSign = st_reg.sbuf[4'(snb - 5'h01)][3:0];
  assign pkDone  = doneStrobe && st_reg.pack && !st_reg.bad;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  AST_DONE_TIMING: assert property (startOk |=> ##1 doneStrobe ##1 !doneStrobe)
    else $error("completion strobe not two cycles after start");
  AST_ZERO_POS: assert property (doneStrobe && !st_reg.bad && st_reg.dig == '0 |-> !resultNeg)
    else $error("zero result reported negative");
  AST_NEG_KEPT: assert property (pkDone && $past(st_reg.neg) && st_reg.dig != '0 |-> resultNeg)
    else $error("negative nonzero result lost its sign");
  AST_ZLEN_OVF: assert property (pkDone && dd.len == '0 && st_reg.dig != '0 |-> decOverflow)
    else $error("nonzero result into zero length without overflow");
  AST_SIGNED_NIB: assert property (pkDone && dd.typ == dsc_pkg::T_SPACK |->
      dLast[3:0] == (resultNeg ? dsc_pkg::SG_NEG : dsc_pkg::SG_POS))
    else $error("wrong signed packed sign nibble");
  AST_UNS_NIB: assert property (pkDone && dd.typ == dsc_pkg::T_UPACK |-> dLast[3:0] == dsc_pkg::SG_UNS)
    else $error("wrong unsigned packed sign nibble");
  AST_EVEN_TOP: assert property (pkDone && !dd.len[0] && dd.len != '0 |->
      st_reg.dbuf[0][7:4] == dsc_pkg::NIB_0)
    else $error("even length top nibble not cleared");
  AST_TAIL_ZERO: assert property (pkDone && dnb < 5'(dsc_pkg::NBYTES) |-> st_reg.dbuf[4'(dnb)] == '0)
    else $error("byte beyond packed string written");
  AST_BAD_TYPE: assert property (doneStrobe && !dsc_pkg::is_packed(st_reg.pack ? dd.typ : sd.typ)
      |-> badType)
    else $error("reserved packed type not flagged");
  AST_SRC_NEG: assert property (doneStrobe && !st_reg.pack && sd.typ == dsc_pkg::T_SPACK &&
      srcSign == dsc_pkg::SG_ANEG && st_reg.dig != '0 |-> resultNeg)
    else $error("alternate negative sign not accepted");
  AST_STROBE_ONE: assert property (doneStrobe |=> !doneStrobe)
    else $error("completion strobe longer than one cycle");
  AST_UNPACK_NO_OVF: assert property (doneStrobe && !st_reg.pack |-> !decOverflow)
    else $error("overflow reported after unpack");
  AST_BAD_KEEPS: assert property (doneStrobe && st_reg.bad && st_reg.pack |-> $stable(st_reg.dbuf))
    else $error("reserved type changed the destination bytes");
  AST_BUSY_HOLD: assert property (st_reg.phase != dsc_pkg::PH_IDLE |=>
      $stable(st_reg.sw0) && $stable(st_reg.dw0))
    else $error("descriptor changed while busy");
  AST_LSD_PLACE: assert property (pkDone && dd.len != '0 |-> dLast[7:4] == st_reg.dig[0])
    else $error("least significant digit misplaced");
  AST_LEN1_DIGIT: assert property (pkDone && dd.len == 5'h01 |-> st_reg.dbuf[0][7:4] == st_reg.dig[0])
    else $error("length one digit not in upper nibble");

endmodule
`default_nettype wire

/* tb/exec_unit_model.sv */
// Stand-in for the execution unit: records the status pins at each completion strobe.
// Assumes the codec's status pins, on the same core clock and reset.
`timescale 1ns/1ns
`default_nettype none
module exec_unit_model (
  input  wire logic       core_clk,    // Core clock.
  input  wire logic       nrst,        // Synchronous reset, active low.
  input  wire logic       doneStrobe,  // Completion pulse.
  input  wire logic       decOverflow, // Overflow status.
  input  wire logic       resultNeg,   // Sign status.
  input  wire logic       badType,     // Bad type status.
  output logic      [7:0] doneCount,   // Completions seen.
  output logic      [2:0] lastStat     // Bad, negative, overflow at the last strobe.
);
  // Status is only trusted in the strobe cycle, so it is captured there and nowhere else.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      doneCount <= 8'h00;
      lastStat  <= 3'h0;
    end else if (doneStrobe) begin
      doneCount <= doneCount + 8'h01;
      lastStat  <= {badType, resultNeg, decOverflow};
    end
  end
endmodule
`default_nettype wire

/* tb/tb_dsc_codec.sv */
// Self-checking bench for the decimal string codec.
// Assumes the codec package and the execution-unit stand-in are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_dsc_codec;
  logic        core_clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        doneStrobe;
  logic        decOverflow;
  logic        resultNeg;
  logic        badType;
  logic [7:0]  doneCount;
  logic [2:0]  lastStat;
  logic [31:0] rd;
  logic        lastErr;
  int          errors;
  int          checks_done;

  dsc_codec uut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .doneStrobe(doneStrobe), .decOverflow(decOverflow), .resultNeg(resultNeg), .badType(badType));
  exec_unit_model partner (.core_clk(core_clk), .nrst(nrst), .doneStrobe(doneStrobe),
    .decOverflow(decOverflow), .resultNeg(resultNeg), .badType(badType),
    .doneCount(doneCount), .lastStat(lastStat));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Ready, error and read data are taken at the rising edge that ends the access cycle, before
  // the slave's registers move on that edge, so the request stands until it is answered.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic rdy;
    rdy = 1'b0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (int n = 0; n < 16 && !rdy; n++) begin
      @(posedge core_clk);
      rdy = (pready === 1'b1);
      rd = prdata;
      lastErr = pslverr;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    check({31'h0, rdy}, 32'h1);
  endtask

  task automatic writeDig(input logic [127:0] v);
    for (int i = 0; i < 4; i++) apb(1'b1, dsc_pkg::A_DIG + 8'(i * 4), v[32 * i +: 32]);
  endtask

  task automatic runOp(input logic [31:0] ctrl);
    apb(1'b1, dsc_pkg::A_CTRL, ctrl);
    rd = 32'h0;
    for (int n = 0; n < 20 && rd[dsc_pkg::S_DONE] !== 1'b1; n++) apb(1'b0, dsc_pkg::A_STAT, 32'h0);
    check({31'h0, rd[dsc_pkg::S_BUSY]}, 32'h0);
  endtask

  task automatic pack(input logic [15:0] w0, input logic sg, input logic [31:0] expW, input logic [2:0] expStat);
    logic [7:0] cnt;
    apb(1'b1, dsc_pkg::A_DD0, {16'h0, w0});
    apb(1'b1, dsc_pkg::A_SIGN, {31'h0, sg});
    cnt = doneCount;
    runOp(32'h2);
    apb(1'b0, dsc_pkg::A_DBUF, 32'h0);
    check(rd, expW);
    check({29'h0, lastStat}, {29'h0, expStat});
    check({24'h0, doneCount}, {24'h0, cnt + 8'h01});
  endtask

  task automatic unpack(input logic [15:0] w0, input logic [31:0] sb, input logic [31:0] expDig, input logic expNeg);
    apb(1'b1, dsc_pkg::A_SD0, {16'h0, w0});
    apb(1'b1, dsc_pkg::A_SBUF, sb);
    runOp(32'h1);
    apb(1'b0, dsc_pkg::A_DIG, 32'h0);
    check(rd, expDig);
    apb(1'b0, dsc_pkg::A_SIGN, 32'h0);
    check(rd, {31'h0, expNeg});
    check({29'h0, lastStat}, {30'h0, expNeg, 1'b0});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    check({28'h0, doneStrobe, decOverflow, resultNeg, badType}, 32'h0);
    apb(1'b0, dsc_pkg::A_STAT, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    check({31'h0, lastErr}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, dsc_pkg::A_SD1, 32'hFFFF1234);
    apb(1'b0, dsc_pkg::A_SD1, 32'h0);
    check(rd, 32'h00001234);
    apb(1'b1, dsc_pkg::A_DD0, 32'hFFFF7FFF);
    apb(1'b0, dsc_pkg::A_DD0, 32'h0);
    check(rd, 32'h00007FFF);
    $display("test reset done");
  endtask

  task automatic t_signed();
    writeDig(128'h321);
    pack(16'h6003, 1'b0, 32'h00001C32, 3'b000);
    writeDig(128'h4321);
    pack(16'h6004, 1'b1, 32'h001D3204, 3'b010);
    $display("test signed pack done");
  endtask

  task automatic t_fill_overflow();
    writeDig(128'h42);
    pack(16'h6005, 1'b0, 32'h002C0400, 3'b000);
    writeDig(128'h21);
    pack(16'h6001, 1'b1, 32'h0000001D, 3'b011);
    writeDig(128'h10);
    pack(16'h6001, 1'b1, 32'h0000000D, 3'b011);
    writeDig(128'h0);
    pack(16'h6002, 1'b1, 32'h00000C00, 3'b000);
    $display("test fill and overflow done");
  endtask

  task automatic t_zero_len();
    writeDig(128'h5);
    pack(16'h6000, 1'b0, 32'h0000000C, 3'b001);
    pack(16'h6000, 1'b1, 32'h0000000D, 3'b011);
    writeDig(128'h0);
    pack(16'h6000, 1'b1, 32'h0000000C, 3'b000);
    $display("test zero length done");
  endtask

  task automatic t_unsigned_long();
    writeDig(128'h99);
    pack(16'h7002, 1'b0, 32'h00009F09, 3'b000);
    writeDig({32'h09999999, {3{32'h99999999}}});
    pack(16'h601F, 1'b0, 32'h99999999, 3'b000);
    apb(1'b0, dsc_pkg::A_DBUF + 8'h0C, 32'h0);
    check(rd, 32'h9C999999);
    $display("test unsigned and long done");
  endtask

  task automatic t_unpack();
    logic [3:0] sg;
    unpack(16'h6003, 32'h00001C32, 32'h321, 1'b0);
    for (int i = 0; i < 6; i++) begin
      sg = 4'hA + 4'(i);
      unpack(16'h6001, {24'h0, 4'h7, sg}, 32'h7, (sg == 4'hB) || (sg == 4'hD));
    end
    unpack(16'h6003, 32'h00000D00, 32'h0, 1'b0);
    unpack(16'h7001, 32'h0000007F, 32'h7, 1'b0);
    unpack(16'h6004, 32'h001D3204, 32'h4321, 1'b1);
    unpack(16'h6000, 32'h0000000D, 32'h0, 1'b0);
    $display("test unpack done");
  endtask

  task automatic t_bad_type();
    writeDig(128'h5);
    pack(16'h6001, 1'b0, 32'h0000005C, 3'b000);
    for (int t = 0; t < 6; t++) pack({1'b0, 3'(t), 12'h001}, 1'b0, 32'h0000005C, 3'b100);
    $display("test reserved types done");
  endtask

  // ****************************************************************
  // Run control
  // ****************************************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // The full run needs under a thousand cycles; this bound leaves ample margin.
  initial begin
    repeat (30000) @(posedge core_clk);
    errors++;
    print_verdict();
  end

  initial begin
    errors = 0;
    checks_done = 0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_signed();
    t_fill_overflow();
    t_zero_len();
    t_unsigned_long();
    t_unpack();
    t_bad_type();
    print_verdict();
  end
endmodule
`default_nettype wire
